// ### rtl/rcp_pkg.sv
// ==========================================================================
// Shared constants for the receiver clock and polling control block.
// ==========================================================================
package rcp_pkg;

    // ======================================================================
    // Register port geometry and offsets.
    // ======================================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_OPCFG = 4'h0;     // Operating configuration register.
    localparam logic [3:0] ADDR_STATUS = 4'h1;    // Live state of the controller.
    localparam logic [3:0] ADDR_SLEEPCNT = 4'h2;  // Remaining sleep count, low 16 bits.

    // ======================================================================
    // Field layout of the operating configuration register.
    // ======================================================================
    localparam int OPCFG_SLEEP_LSB = 0;   // Five-bit sleep count.
    localparam int OPCFG_SLEEP_W = 5;
    localparam int OPCFG_XSTD_BIT = 5;    // Standard sleep extension.
    localparam int OPCFG_XTEMP_BIT = 6;   // Temporary sleep extension.
    localparam int OPCFG_BAUD_LSB = 7;    // Two-bit baud range, binary 0 to 3.
    localparam int OPCFG_BAUD_W = 2;
    localparam int OPCFG_LINE_BIT = 9;    // 0: one shared line, 1: separate lines.
    localparam int OPCFG_START_LSB = 10;  // Start-up length in baud-scaled periods.
    localparam int OPCFG_START_W = 6;
    localparam logic [15:0] OPCFG_RST = 16'h400A;

    // Sleep count value that parks the receiver asleep until reprogrammed.
    localparam logic [4:0] SLEEP_PERMANENT = 5'h1F;
    // Sleep time is count x extension x 1024 basic periods; both factors are powers of two.
    localparam int SLEEP_UNIT_SHIFT = 10;
    localparam int SLEEP_EXTENSION_FACTOR_SHIFT = 3;
    localparam int SLEEP_CNT_W = 18;

    // ======================================================================
    // Basic clock generation.
    // ======================================================================
    localparam logic [3:0] XTAL_DIV_MODE_LOW = 4'hA;   // 4.90625 MHz / 10.
    localparam logic [3:0] XTAL_DIV_MODE_HIGH = 4'hE;  // 6.76438 MHz / 14.
    localparam int BASIC_PERIOD_LOW_PS = 2038300;
    localparam int BASIC_PERIOD_HIGH_PS = 2069700;
    localparam int CLOCK_PERIOD_PS = 8000;
    // Missing-crystal timeout: two of the longer basic periods, rounded down.
    localparam int XTAL_LOSS_CYCLES = (2 * BASIC_PERIOD_HIGH_PS) / CLOCK_PERIOD_PS;
    localparam int XTAL_LOSS_W = 10;

    // Baud-scaled period in basic periods for ranges 0, 1, 2 and 3.
    localparam logic [3:0] XCLK_DIV_R0 = 4'h8;
    localparam logic [3:0] XCLK_DIV_R1 = 4'h4;
    localparam logic [3:0] XCLK_DIV_R2 = 4'h2;
    localparam logic [3:0] XCLK_DIV_R3 = 4'h1;

    // ======================================================================
    // Polling controller states, one-hot.
    // ======================================================================
    typedef enum logic [4:0] {
        ST_OFF      = 5'h01,
        ST_SLEEP    = 5'h02,
        ST_STARTUP  = 5'h04,
        ST_BITCHECK = 5'h08,
        ST_RECEIVE  = 5'h10
    } rcp_state_e;

    // Pulls the baud range out of a configuration word; used by both the
    // low-pass selector and the divider programming.
    function automatic logic [1:0] rcp_baud_range(input logic [15:0] cfg);
        rcp_baud_range = cfg[OPCFG_BAUD_LSB +: OPCFG_BAUD_W];
    endfunction

endpackage

// ### rtl/rcp_clk_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Clock generation signals between the controller and its divider.
// ==========================================================================
interface rcp_clk_if;
    logic crystal_tick;     // One pulse per crystal oscillator cycle.
    logic mode_sel;         // Frequency-select strap level.
    logic [1:0] baud_range; // Baud range setting.
    logic basic_tick;       // One pulse per basic clock period.
    logic baud_tick;        // One pulse per baud-scaled clock period.

    modport ctl (output crystal_tick, output mode_sel, output baud_range,
                 input basic_tick, input baud_tick);
    modport div (input crystal_tick, input mode_sel, input baud_range,
                 output basic_tick, output baud_tick);
endinterface

// ### rtl/rcp_divider.sv
`timescale 1ns/1ps
// ==========================================================================
// Crystal divider: basic clock and baud-scaled clock ticks.
// ==========================================================================
module rcp_divider
    import rcp_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Divider side of the clock interface.
    rcp_clk_if.div ck
);

    logic [3:0] xtal_cnt_q, xtal_cnt_d;  // Crystal cycles within a basic period.
    logic [3:0] baud_cnt_q, baud_cnt_d;  // Basic periods within a baud period.
    logic basic_q, basic_d;              // Registered basic tick.
    logic baud_q, baud_d;                // Registered baud tick.
    logic [3:0] xtal_div;                // Divide factor from the strap.
    logic [3:0] baud_div;                // Divide factor from the baud range.

    // ======================================================================
    // Next-state logic.
    // ======================================================================
    // The strap is read live, so changing it retimes the period already in progress.
    always_comb begin
        xtal_div = ck.mode_sel ? XTAL_DIV_MODE_HIGH : XTAL_DIV_MODE_LOW;
        case (ck.baud_range)
            2'h0: baud_div = XCLK_DIV_R0;
            2'h1: baud_div = XCLK_DIV_R1;
            2'h2: baud_div = XCLK_DIV_R2;
            default: baud_div = XCLK_DIV_R3;
        endcase
        xtal_cnt_d = xtal_cnt_q;
        baud_cnt_d = baud_cnt_q;
        basic_d = 1'b0;
        baud_d = 1'b0;
        if (ck.crystal_tick) begin
            if (xtal_cnt_q >= xtal_div - 4'h1) begin
                // A basic period ends; the baud counter advances on it.
                xtal_cnt_d = 4'h0;
                basic_d = 1'b1;
                if (baud_cnt_q >= baud_div - 4'h1) begin
                    baud_cnt_d = 4'h0;
                    baud_d = 1'b1;
                end else begin
                    baud_cnt_d = baud_cnt_q + 4'h1;
                end
            end else begin
                xtal_cnt_d = xtal_cnt_q + 4'h1;
            end
        end
    end

    // ======================================================================
    // Registers.
    // ======================================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xtal_cnt_q <= 4'h0;
            baud_cnt_q <= 4'h0;
            basic_q <= 1'b0;
            baud_q <= 1'b0;
        end else begin
            xtal_cnt_q <= xtal_cnt_d;
            baud_cnt_q <= baud_cnt_d;
            basic_q <= basic_d;
            baud_q <= baud_d;
        end
    end

    assign ck.basic_tick = basic_q;
    assign ck.baud_tick = baud_q;

endmodule

// ### rtl/rcp_top.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Basic clock divides crystal by strap-chosen factor
// - Strap low 2.0383 us, high 2.0697 us
// - Basic clock times polling, programming, filter tuning
// - Baud clock is 8,4,2,1 basic periods
// - Baud range selects data low-pass cutoff
// - Polling briefly enables path for bit check
// - Stay active only on valid signal, else sleep
// - Host may write every polling parameter
// - Host link: one shared line or separate lines
// - Enable low sleeps, enable high runs polling
// - Sleep is count x extension x 1024 periods
module rcp_top
    import rcp_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_B,
    // Crystal oscillator tick and frequency-select strap.
    input wire logic CRYSTAL_OSC_TICK,
    input wire logic MODE_SEL,
    // Host control and data lines.
    input wire logic ENABLE,
    input wire logic DATA_IN,
    output logic DATA_OUT,
    output logic DATA_OE_B,
    output logic RX_DATA_OUT,
    // Register port.
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    // Signal path and bit-check logic.
    input wire logic DEMOD_DATA,
    input wire logic BITCHECK_OK,
    input wire logic BITCHECK_FAIL,
    output logic SIGNAL_PATH_EN,
    output logic BITCHECK_EN,
    output logic [1:0] LOWPASS_SEL,
    output logic BASIC_TICK,
    output logic BAUD_TICK
);

    // ======================================================================
    // Declarations.
    // ======================================================================
    rcp_clk_if ck ();                         // Link to the divider.

    logic [DATA_W-1:0] opcfg_q, opcfg_d;      // Operating configuration register.
    logic [DATA_W-1:0] rdata_q, rdata_d;      // Read data, valid the cycle after a read.
    rcp_state_e state_q, state_d;             // Polling controller state.
    logic [SLEEP_CNT_W-1:0] sleep_q, sleep_d; // Basic periods left in sleep.
    logic [OPCFG_START_W-1:0] start_q, start_d; // Baud periods left in start-up.
    logic [XTAL_LOSS_W-1:0] wd_q, wd_d;       // Cycles since the last basic tick.
    logic alive_q, alive_d;                   // Crystal seen recently.
    logic path_q, path_d;                     // Signal path enable.
    logic chk_q, chk_d;                       // Bit check enable.
    logic dout_q, dout_d;                     // Shared data line output.
    logic oe_b_q, oe_b_d;                     // Shared data line enable, low drives.
    logic rxo_q, rxo_d;                       // Separate data output.
    logic fail_clear;                         // Bit check failed this cycle.
    logic [4:0] sleep_field;                  // Programmed sleep count.
    logic sleep_ext;                          // Standard extension set, or temporary one with no failing check.
    logic [SLEEP_CNT_W-1:0] sleep_load;       // Sleep length for a fresh sleep.

    // ======================================================================
    // Divider instance.
    // ======================================================================
    assign ck.crystal_tick = CRYSTAL_OSC_TICK;
    assign ck.mode_sel = MODE_SEL;
    assign ck.baud_range = rcp_baud_range(opcfg_q);

    rcp_divider u_div (
        .clk(CLOCK),
        .rst_b(RST_B),
        .ck(ck)
    );

    // ======================================================================
    // Configuration register.
    // ======================================================================
    // A host write lands last, so writing the temporary extension back to
    // one in the cycle the hardware clears it keeps the one.
    always_comb begin
        fail_clear = state_q == ST_BITCHECK && BITCHECK_FAIL;
        opcfg_d = opcfg_q;
        if (fail_clear) begin
            opcfg_d[OPCFG_XTEMP_BIT] = 1'b0;
        end
        if (WR && ADDR == ADDR_OPCFG) begin
            opcfg_d = WDATA;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            opcfg_q <= OPCFG_RST;
        end else begin
            opcfg_q <= opcfg_d;
        end
    end

    // ======================================================================
    // Read port.
    // ======================================================================
    // Unmapped offsets read as zero; data stands only in the cycle after RD.
    always_comb begin
        rdata_d = '0;
        if (RD) begin
            if (ADDR == ADDR_OPCFG) begin
                rdata_d = opcfg_q;
            end else if (ADDR == ADDR_STATUS) begin
                rdata_d = {5'h00, MODE_SEL, DATA_IN, alive_q, opcfg_q[OPCFG_XTEMP_BIT],
                           rcp_baud_range(opcfg_q), state_q};
            end else if (ADDR == ADDR_SLEEPCNT) begin
                rdata_d = sleep_q[DATA_W-1:0];
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // Crystal watchdog.
    // ======================================================================
    // Without crystal ticks the controller simply freezes, so software gets
    // a status bit rather than a silent hang.
    always_comb begin
        wd_d = wd_q;
        alive_d = alive_q;
        if (ck.basic_tick) begin
            wd_d = '0;
            alive_d = 1'b1;
        end else if (wd_q >= XTAL_LOSS_W'(XTAL_LOSS_CYCLES)) begin
            alive_d = 1'b0;
        end else begin
            wd_d = wd_q + XTAL_LOSS_W'(1);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wd_q <= '0;
            alive_q <= 1'b0;
        end else begin
            wd_q <= wd_d;
            alive_q <= alive_d;
        end
    end

    // ======================================================================
    // Polling controller.
    // ======================================================================
    // Sleep length is the count shifted by 10, and by 3 more when extended.
    always_comb begin
        sleep_field = opcfg_q[OPCFG_SLEEP_LSB +: OPCFG_SLEEP_W];
        // A failing check drops the temporary extension before this reload.
        sleep_ext = opcfg_q[OPCFG_XSTD_BIT] | (opcfg_q[OPCFG_XTEMP_BIT] & ~fail_clear);
        sleep_load = SLEEP_CNT_W'(sleep_field) << SLEEP_UNIT_SHIFT;
        if (sleep_ext) begin
            sleep_load = sleep_load << SLEEP_EXTENSION_FACTOR_SHIFT;
        end
    end

    // All timing counts advance on basic or baud ticks, never on CLOCK.
    always_comb begin
        state_d = state_q;
        sleep_d = sleep_q;
        start_d = start_q;
        if (!ENABLE) begin
            // Enable low stops polling from any state.
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_d = ST_SLEEP;
                    sleep_d = sleep_load;
                end
                ST_SLEEP: begin
                    if (sleep_field == SLEEP_PERMANENT) begin
                        // Parked until another count is written.
                        sleep_d = sleep_load;
                    end else if (sleep_q == '0) begin
                        state_d = ST_STARTUP;
                        start_d = opcfg_q[OPCFG_START_LSB +: OPCFG_START_W];
                    end else if (ck.basic_tick) begin
                        sleep_d = sleep_q - SLEEP_CNT_W'(1);
                    end
                end
                ST_STARTUP: begin
                    if (start_q == '0) begin
                        state_d = ST_BITCHECK;
                    end else if (ck.baud_tick) begin
                        start_d = start_q - OPCFG_START_W'(1);
                    end
                end
                ST_BITCHECK: begin
                    if (BITCHECK_FAIL) begin
                        state_d = ST_SLEEP;
                        sleep_d = sleep_load;
                    end else if (BITCHECK_OK) begin
                        state_d = ST_RECEIVE;
                    end
                end
                ST_RECEIVE: begin
                    state_d = ST_RECEIVE;
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            state_q <= ST_OFF;
            sleep_q <= '0;
            start_q <= '0;
        end else begin
            state_q <= state_d;
            sleep_q <= sleep_d;
            start_q <= start_d;
        end
    end

    // ======================================================================
    // Outputs to the signal path and the host.
    // ======================================================================
    // Outputs follow the next state so they line up with state_q.
    always_comb begin
        path_d = state_d == ST_STARTUP || state_d == ST_BITCHECK || state_d == ST_RECEIVE;
        chk_d = state_d == ST_BITCHECK;
        dout_d = 1'b1;
        oe_b_d = 1'b1;
        rxo_d = 1'b0;
        if (state_d == ST_RECEIVE) begin
            if (opcfg_d[OPCFG_LINE_BIT]) begin
                rxo_d = DEMOD_DATA;
            end else begin
                dout_d = DEMOD_DATA;
                oe_b_d = 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            path_q <= 1'b0;
            chk_q <= 1'b0;
            dout_q <= 1'b1;
            oe_b_q <= 1'b1;
            rxo_q <= 1'b0;
        end else begin
            path_q <= path_d;
            chk_q <= chk_d;
            dout_q <= dout_d;
            oe_b_q <= oe_b_d;
            rxo_q <= rxo_d;
        end
    end

    assign SIGNAL_PATH_EN = path_q;
    assign BITCHECK_EN = chk_q;
    assign DATA_OUT = dout_q;
    assign DATA_OE_B = oe_b_q;
    assign RX_DATA_OUT = rxo_q;
    assign RDATA = rdata_q;
    assign LOWPASS_SEL = rcp_baud_range(opcfg_q);
    assign BASIC_TICK = ck.basic_tick;
    assign BAUD_TICK = ck.baud_tick;

endmodule

// ### verif/rcp_top_properties.sv
`timescale 1ns/1ps
// ========
// Port checker for the clock and polling block.
module rcp_top_properties
    import rcp_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_B,
    // Host side.
    input wire logic ENABLE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic DATA_OUT,
    input wire logic DATA_OE_B,
    // Signal path and ticks.
    input wire logic DEMOD_DATA,
    input wire logic BITCHECK_OK,
    input wire logic BITCHECK_FAIL,
    input wire logic SIGNAL_PATH_EN,
    input wire logic BITCHECK_EN,
    input wire logic [1:0] LOWPASS_SEL,
    input wire logic BASIC_TICK,
    input wire logic BAUD_TICK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    // Basic ticks since the last baud tick; the ratio is judged only if the range held still.
    logic [3:0] bcnt_q;
    logic seen_q;
    logic clean_q;
    logic [1:0] rng_q;

    // Counts basic ticks between baud ticks.
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            bcnt_q <= 4'h0;
            seen_q <= 1'b0;
            clean_q <= 1'b0;
            rng_q <= 2'h0;
        end else if (BAUD_TICK) begin
            bcnt_q <= 4'h0;
            seen_q <= 1'b1;
            clean_q <= 1'b1;
            rng_q <= LOWPASS_SEL;
        end else begin
            if (BASIC_TICK) bcnt_q <= bcnt_q + 4'h1;
            if (LOWPASS_SEL != rng_q) clean_q <= 1'b0;
        end
    end

    chk_baud_ratio: assert property (BAUD_TICK && seen_q && clean_q && LOWPASS_SEL == rng_q
        |-> bcnt_q + 4'h1 == (4'h8 >> LOWPASS_SEL)) else $error("baud period ratio wrong");
    chk_baud_on_basic: assert property (BAUD_TICK |-> BASIC_TICK) else $error("baud tick off grid");
    chk_basic_gap: assert property (BASIC_TICK |=> !BASIC_TICK [*8]) else $error("basic ticks too close");
    chk_lowpass_write: assert property (WR && ADDR == ADDR_OPCFG
        |=> LOWPASS_SEL == $past(WDATA[OPCFG_BAUD_LSB +: OPCFG_BAUD_W])) else $error("lowpass not updated");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == '0) else $error("read data outside slot");
    chk_enable_off: assert property (!ENABLE |=> !SIGNAL_PATH_EN && !BITCHECK_EN && DATA_OE_B)
        else $error("enable low did not stop polling");
    chk_check_path: assert property (BITCHECK_EN |-> SIGNAL_PATH_EN) else $error("check without path");
    chk_fail_sleep: assert property (BITCHECK_EN && BITCHECK_FAIL |=> !SIGNAL_PATH_EN)
        else $error("failed check kept path on");
    chk_ok_receive: assert property (BITCHECK_EN && BITCHECK_OK && !BITCHECK_FAIL && ENABLE
        |=> SIGNAL_PATH_EN && !BITCHECK_EN) else $error("good check did not receive");
    chk_rx_follow: assert property (!DATA_OE_B && !$past(DATA_OE_B) |-> DATA_OUT == $past(DEMOD_DATA))
        else $error("shared line data wrong");
endmodule

bind rcp_top rcp_top_properties u_props (.CLOCK, .RST_B, .ENABLE, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .DATA_OUT, .DATA_OE_B, .DEMOD_DATA, .BITCHECK_OK, .BITCHECK_FAIL, .SIGNAL_PATH_EN, .BITCHECK_EN,
    .LOWPASS_SEL, .BASIC_TICK, .BAUD_TICK);

// ### verif/rcp_host_line.sv
`timescale 1ns/1ps
// ========
// Host end of the shared data line, with its pull-up.
module rcp_host_line (
    // Device side.
    input wire logic dev_out,
    input wire logic dev_oe_b,
    // Host side.
    input wire logic host_oe_b,
    input wire logic host_out,
    // Resolved level.
    output logic line
);
    // Either party may pull low; an undriven line floats high, never to a stale value.
    always_comb begin
        line = (dev_oe_b | dev_out) & (host_oe_b | host_out);
    end
endmodule

// ### verif/rcp_top_test.sv
`timescale 1ns/1ps
// ========
// Self-checking bench for the clock and polling block.
module rcp_top_test
    import rcp_pkg::*;
;
    logic CLOCK = 1'b0, RST_B = 1'b0, CRYSTAL_OSC_TICK = 1'b0, MODE_SEL = 1'b0, ENABLE = 1'b0;
    logic DEMOD_DATA = 1'b0, BITCHECK_OK = 1'b0, BITCHECK_FAIL = 1'b0, WR = 1'b0, RD = 1'b0;
    logic host_oe_b = 1'b1, host_out = 1'b1;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0, RDATA, rv;
    logic DATA_IN, DATA_OUT, DATA_OE_B, RX_DATA_OUT, SIGNAL_PATH_EN, BITCHECK_EN, BASIC_TICK, BAUD_TICK;
    logic [1:0] LOWPASS_SEL;
    int bad_count = 0;
    int checked = 0;
    int n;

    always #4 CLOCK = ~CLOCK;
    // The crystal runs at full rate once reset is released.
    always @(posedge CLOCK) CRYSTAL_OSC_TICK <= RST_B;

    rcp_top DUT (.CLOCK, .RST_B, .CRYSTAL_OSC_TICK, .MODE_SEL, .ENABLE, .DATA_IN, .DATA_OUT, .DATA_OE_B,
        .RX_DATA_OUT, .ADDR, .WDATA, .WR, .RD, .RDATA, .DEMOD_DATA, .BITCHECK_OK, .BITCHECK_FAIL,
        .SIGNAL_PATH_EN, .BITCHECK_EN, .LOWPASS_SEL, .BASIC_TICK, .BAUD_TICK);
    rcp_host_line u_host (.dev_out(DATA_OUT), .dev_oe_b(DATA_OE_B), .host_oe_b(host_oe_b),
        .host_out(host_out), .line(DATA_IN));

    // ========
    // Shared tasks.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLOCK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        d = RDATA;
    endtask
    // Waits for a basic tick (0), baud tick (1) or bit check (2) under a bound.
    task automatic wait_for(input int sel, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(negedge CLOCK);
            if ((sel == 0 && BASIC_TICK === 1'b1) || (sel == 1 && BAUD_TICK === 1'b1)
                || (sel == 2 && BITCHECK_EN === 1'b1)) return;
        end
        bad_count++;
        $display("unexpected wait: expected event %0d, seen none", sel);
        give_verdict();
    endtask
    // Counts basic ticks spent asleep until the path wakes.
    task automatic count_sleep(output int cnt);
        cnt = 0;
        for (int i = 0; i < 12000; i++) begin
            @(negedge CLOCK);
            if (SIGNAL_PATH_EN === 1'b1) return;
            cnt += (BASIC_TICK === 1'b1);
        end
        bad_count++;
        $display("unexpected sleep end: expected path enable, seen none");
        give_verdict();
    endtask
    task automatic follow(input logic sep);
        for (int i = 0; i < 4; i++) begin
            @(posedge CLOCK);
            DEMOD_DATA <= i[0];
            @(posedge CLOCK);
            @(negedge CLOCK);
            check("rx data", 16'(sep ? RX_DATA_OUT : DATA_OUT), 16'(i[0]));
        end
    endtask

    // ========
    // Scenarios.
    task automatic t_reset_values;
        rd(ADDR_OPCFG, rv);
        check("opcfg reset", rv, 16'h400A);
        check("lowpass reset", 16'(LOWPASS_SEL), 16'h0000);
        rd(4'hF, rv);
        check("unmapped read", rv, 16'h0000);
        wr(ADDR_STATUS, 16'hFFFF);
        @(posedge CLOCK);
        host_oe_b <= 1'b0;
        host_out <= 1'b0;
        rd(ADDR_STATUS, rv);
        check("state", 16'(rv[4:0]), 16'h0001);
        check("line level", 16'(rv[9]), 16'h0000);
        @(posedge CLOCK);
        host_oe_b <= 1'b1;
    endtask
    task automatic t_basic_clock;
        for (int m = 0; m < 2; m++) begin
            @(posedge CLOCK);
            MODE_SEL <= m[0];
            wait_for(0, 40);
            wait_for(0, 40);
            n = 0;
            do begin
                @(negedge CLOCK);
                n++;
            end while (BASIC_TICK !== 1'b1 && n < 40);
            check("basic period", 16'(n), m ? 16'h000E : 16'h000A);
            rd(ADDR_STATUS, rv);
            check("strap level", 16'(rv[10]), 16'(m));
            check("crystal alive", 16'(rv[8]), 16'h0001);
        end
        @(posedge CLOCK);
        MODE_SEL <= 1'b0;
    endtask
    task automatic t_baud;
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_OPCFG, 16'(r) << 7);
            @(negedge CLOCK);
            check("lowpass", 16'(LOWPASS_SEL), 16'(r));
            wait_for(1, 200);
            n = 0;
            do begin
                @(negedge CLOCK);
                n += (BASIC_TICK === 1'b1);
            end while (BAUD_TICK !== 1'b1 && n < 20);
            check("baud ratio", 16'(n), 16'h0008 >> r);
        end
    endtask
    task automatic t_polling;
        wr(ADDR_OPCFG, 16'h0981);
        @(posedge CLOCK);
        ENABLE <= 1'b1;
        @(posedge CLOCK);
        count_sleep(n);
        check("sleep ticks", 16'(n), 16'h0400);
        wr(ADDR_OPCFG, 16'h09C1);
        wait_for(2, 100);
        rd(ADDR_STATUS, rv);
        check("check state", 16'(rv[4:0]), 16'h0008);
        @(posedge CLOCK);
        BITCHECK_FAIL <= 1'b1;
        @(posedge CLOCK);
        BITCHECK_FAIL <= 1'b0;
        count_sleep(n);
        check("sleep after fail", 16'(n), 16'h0400);
        rd(ADDR_OPCFG, rv);
        check("temp extension", 16'(rv[6]), 16'h0000);
        wait_for(2, 100);
        @(posedge CLOCK);
        BITCHECK_OK <= 1'b1;
        @(posedge CLOCK);
        BITCHECK_OK <= 1'b0;
        rd(ADDR_STATUS, rv);
        check("receive state", 16'(rv[4:0]), 16'h0010);
        check("line driven", 16'(DATA_OE_B), 16'h0000);
        follow(1'b0);
        wr(ADDR_OPCFG, 16'h0B81);
        follow(1'b1);
        @(posedge CLOCK);
        ENABLE <= 1'b0;
        @(posedge CLOCK);
        @(negedge CLOCK);
        check("path off", 16'({SIGNAL_PATH_EN, DATA_OE_B}), 16'h0001);
    endtask
    task automatic t_perm_sleep;
        wr(ADDR_OPCFG, 16'h09BF);
        @(posedge CLOCK);
        ENABLE <= 1'b1;
        n = 0;
        repeat (3000) begin
            @(negedge CLOCK);
            n += (SIGNAL_PATH_EN === 1'b1);
        end
        check("permanent sleep", 16'(n), 16'h0000);
        rd(ADDR_SLEEPCNT, rv);
        check("parked count", rv, 16'hE000);
        @(posedge CLOCK);
        ENABLE <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_reset_values();
        t_basic_clock();
        t_baud();
        t_polling();
        t_perm_sleep();
        give_verdict();
    end
endmodule
